// ### design/watchdog_downcounter.sv
`timescale 1ns/1ps
module watchdog_downcounter
	import wdg_pkg::*;
#(
	parameter bit HW_ACTIVATION = 1'b0,  // build option: always active
	parameter bit EXT_STOP_CTRL = 1'b0,  // build option: pin gates stop
	parameter int PRESCALE_DIV  = wdg_pkg::PRESCALE
) (
	// clock and reset
	input  wire logic           sys_clk,
	input  wire logic           sys_rst,
	// data-space access
	input  wdg_pkg::bus_req_t   bus_req,
	output logic [7:0]          bus_rdata,
	// core power control
	input  wire logic           stop_req,   // stop instruction, pulse
	input  wire logic           wake_irq,   // interrupt exits stop, pulse
	input  wire logic           nmi_pin,    // asynchronous pin level
	output logic                stop_mode,  // oscillator may halt
	output logic                stop_as_wait, // stop taken as wait, pulse
	// reset request to the system
	output logic                sys_reset_req
);
	import wdg_pkg::*;

	// register field to counter: bit 7 is the counter lsb, bit 1 its msb
	function automatic logic [CNT_W-1:0] reg_to_cnt(input logic [7:0] d);
		logic [CNT_W-1:0] c;
		c = '0;
		for (int i = 0; i < CNT_W; i++) begin
			c[i] = d[CNT_LSB_POS - i];
		end
		return c;
	endfunction : reg_to_cnt

	// counter to register field, activation bit in bit 0
	function automatic logic [7:0] cnt_to_reg(input logic [CNT_W-1:0] c,
		input logic act);
		logic [7:0] d;
		d = '0;
		for (int i = 0; i < CNT_W; i++) begin
			d[CNT_LSB_POS - i] = c[i];
		end
		d[CTRL_BIT] = act;
		return d;
	endfunction : cnt_to_reg

	localparam logic [CNT_W-1:0] RST_CNT = reg_to_cnt(WDG_RST_VAL);

	logic [CNT_W-1:0] cnt_reg;       // physical downcounter
	logic             en_reg;        // software activation latch
	logic             active;        // watchdog armed
	logic             nmi_meta_reg;  // pin synchroniser, first stage
	logic             nmi_sync_reg;  // pin synchroniser, second stage
	stop_state_t      state_reg;     // stop control state
	logic             hit;           // access to our location
	logic             wr_hit;        // register write this cycle
	logic             sr_clear;      // software-reset bit written low
	logic             tick;          // one count step
	logic             expire;        // bit 6 about to fall while armed
	logic             allow_stop;    // stop may really halt
	logic [7:0]       rdata_reg;     // registered read data
	logic             rst_req_reg;   // registered reset request
	logic             wait_reg;      // registered stop-as-wait pulse

	assign hit    = (bus_req.addr == WDG_ADDR);
	assign wr_hit = hit && bus_req.wr;
	// a write with the bit low fires even if it was already low
	assign sr_clear = wr_hit && !bus_req.wdata[SR_BIT];
	// hardware option ignores the latch entirely
	assign active = HW_ACTIVATION ? 1'b1 : en_reg;

	// pin level reaches logic only through two flops
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			nmi_meta_reg <= 1'b0;
			nmi_sync_reg <= 1'b0;
		end else begin
			nmi_meta_reg <= nmi_pin;
			nmi_sync_reg <= nmi_meta_reg;
		end
	end

	// step enable; a write restarts the period so a fresh reload or
	// activation always gets a full PRESCALE_DIV cycles before the next step
	wdg_prescaler #(
		.DIV   (PRESCALE_DIV)
	) u_pre (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.run     (state_reg == ST_RUN),
		.clear   (wr_hit),
		.tick    (tick)
	);

	// expiry only counts while armed: an unarmed counter just wraps
	assign expire = active && tick && !wr_hit && cnt_reg[CNT_TOP]
		&& (cnt_reg[CNT_TOP-1:0] == '0);

	// downcounter: write reloads, else one step per tick, frozen in stop
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cnt_reg <= RST_CNT;
		end else if (wr_hit) begin
			cnt_reg <= reg_to_cnt(bus_req.wdata);
		end else if (tick) begin
			cnt_reg <= cnt_reg - CNT_ONE;
		end
	end

	// activation latch: set by software, cleared only by system reset
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			en_reg <= WDG_RST_VAL[CTRL_BIT];
		end else if (wr_hit && bus_req.wdata[CTRL_BIT]) begin
			en_reg <= 1'b1;
		end
	end

	// reset request, one cycle; the system answers with sys_rst
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rst_req_reg <= 1'b0;
		end else begin
			rst_req_reg <= sr_clear || expire;
		end
	end

	// read data held in a flop, taken on the read strobe
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rdata_reg <= 8'h00;
		end else if (hit && bus_req.rd) begin
			rdata_reg <= cnt_to_reg(cnt_reg, active);
		end
	end

	// stop may halt only when unarmed, or with pin gating and pin high
	assign allow_stop = !active
		|| (EXT_STOP_CTRL && nmi_sync_reg);

	// stop control: enter on a permitted stop, leave on an interrupt
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_reg <= ST_RUN;
			wait_reg  <= 1'b0;
		end else begin
			wait_reg <= 1'b0;
			case (state_reg)
				ST_RUN: begin
					if (stop_req && allow_stop) begin
						state_reg <= ST_STOP;
					end else if (stop_req) begin
						wait_reg <= 1'b1;
					end
				end
				ST_STOP: begin
					// counter resumes from where it was held
					if (wake_irq) begin
						state_reg <= ST_RUN;
					end
				end
				default: begin
					state_reg <= ST_RUN;
				end
			endcase
		end
	end

	assign bus_rdata     = rdata_reg;
	assign sys_reset_req = rst_req_reg;
	assign stop_mode     = (state_reg == ST_STOP);
	assign stop_as_wait  = wait_reg;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	// helper: count of ticks is spaced by the prescaler
	sequence quiet_s;
		!tick [*8];
	endsequence

	reset_value_a: assert property (
		disable iff (1'b0) $past(sys_rst) |-> cnt_reg == RST_CNT && !en_reg)
		else $error("register not at reset value");
	sr_clear_a: assert property (
		sr_clear |=> sys_reset_req)
		else $error("software-reset clear did not reset");
	write_order_a: assert property (
		wr_hit |=> cnt_reg == reg_to_cnt($past(bus_req.wdata)))
		else $error("write did not reload reversed count");
	expiry_fire_a: assert property (
		active && tick && !wr_hit && cnt_reg == 7'h40 |=> sys_reset_req)
		else $error("bit 6 falling did not reset");
	// a reset needs a low software-reset write or an armed expiry step
	cause_check_a: assert property (
		sys_reset_req |-> ($past(wr_hit) && !$past(bus_req.wdata[SR_BIT]))
			|| ($past(active) && $past(tick) && !$past(wr_hit)
			&& $past(cnt_reg) == 7'h40))
		else $error("reset without a cause");
	// the bus must see the forced activation bit, not just the wire
	hw_active_a: assert property (
		HW_ACTIVATION && hit && bus_req.rd |=> bus_rdata[CTRL_BIT])
		else $error("hardware option not active");
	sticky_en_a: assert property (
		en_reg |=> en_reg)
		else $error("activation bit cleared by software");
	tick_space_a: assert property (
		tick |=> quiet_s)
		else $error("count steps too close");
	stop_freeze_a: assert property (
		stop_mode && !wr_hit |=> $stable(cnt_reg))
		else $error("counter moved in stop");
	stop_wait_a: assert property (
		!stop_mode && stop_req && !allow_stop |=> !stop_mode && stop_as_wait)
		else $error("refused stop not taken as wait");
	wake_resume_a: assert property (
		stop_mode && wake_irq |=> !stop_mode)
		else $error("interrupt did not leave stop");
	reload_grace_a: assert property (
		wr_hit |=> !tick [*8])
		else $error("step too soon after reload");
	read_back_a: assert property (
		hit && bus_req.rd |=> bus_rdata == cnt_to_reg($past(cnt_reg),
			$past(active)))
		else $error("read data wrong");
endmodule : watchdog_downcounter

// ### design/wdg_pkg.sv
package wdg_pkg;
	// data-space location of the watchdog register
	localparam logic [7:0] WDG_ADDR      = 8'hD8;
	// register value after reset: counting bits and the software-reset bit
	// set, activation cleared
	localparam logic [7:0] WDG_RST_VAL   = 8'hFE;
	// register field positions
	localparam int         CTRL_BIT      = 0;
	localparam int         SR_BIT        = 1;
	localparam int         CNT_LSB_POS   = 7;
	// downcounter width and the bit that fires the reset
	localparam int         CNT_W         = 7;
	localparam int         CNT_TOP       = 6;
	localparam logic [6:0] CNT_RST_VAL   = 7'h7F;
	localparam logic [6:0] CNT_ONE       = 7'h01;
	// oscillator cycles per downcounter step
	localparam int         PRESCALE      = 3072;

	// one data-space access from the core
	typedef struct packed {
		logic [7:0] addr;   // data-space address
		logic       wr;     // write strobe, one cycle
		logic       rd;     // read strobe, one cycle
		logic [7:0] wdata;  // write data
	} bus_req_t;

	// stop control states, one-hot
	typedef enum logic [1:0] {
		ST_RUN  = 2'b01,
		ST_STOP = 2'b10
	} stop_state_t;
endpackage : wdg_pkg

// ### design/wdg_prescaler.sv
`timescale 1ns/1ps
// divides the oscillator clock into a one-cycle step enable
module wdg_prescaler #(
	parameter int DIV = 3072
) (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	// control
	input  wire logic run,    // low holds the count (stop mode)
	input  wire logic clear,  // restart a full period
	// step enable
	output logic      tick
);
	localparam int W = $clog2(DIV);
	localparam logic [W-1:0] LAST = W'(DIV - 1);
	localparam logic [W-1:0] ZERO = '0;
	localparam logic [W-1:0] ONE  = W'(1);

	logic [W-1:0] div_reg;  // cycles elapsed in this period

	// clear wins so a reload always buys a whole first period
	always_ff @(posedge sys_clk) begin
		if (sys_rst || clear) begin
			div_reg <= ZERO;
		end else if (run) begin
			div_reg <= (div_reg == LAST) ? ZERO : div_reg + ONE;
		end
	end

	assign tick = run && !clear && (div_reg == LAST);
endmodule : wdg_prescaler

// ### sim/watchdog_downcounter_tb.sv
`timescale 1ns/1ps
module watchdog_downcounter_tb;
	import wdg_pkg::*;
	localparam int DIV   = 16;   // short prescale keeps the run brief
	localparam int LIMIT = 3000; // cycle ceiling against a hang
	// shared stimulus, one set of outputs for each build option
	logic       sys_clk, sys_rst, stop_req, wake_irq, nmi_pin;
	bus_req_t   bus_req;
	logic [7:0] rd_sw, rd_hw;
	logic       stop_sw, stop_hw, wait_sw, wait_hw, rst_sw, rst_hw;
	int         n_errors, n_checks, cycles;
	logic [7:0] rs, rh;
	logic       seen;
	int         k;

	// software-activated build
	watchdog_downcounter #(.PRESCALE_DIV(DIV)) dut (.sys_clk(sys_clk),
		.sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata(rd_sw),
		.stop_req(stop_req), .wake_irq(wake_irq), .nmi_pin(nmi_pin),
		.stop_mode(stop_sw), .stop_as_wait(wait_sw),
		.sys_reset_req(rst_sw));
	// always-active build with pin-gated stop
	watchdog_downcounter #(.HW_ACTIVATION(1'b1), .EXT_STOP_CTRL(1'b1),
		.PRESCALE_DIV(DIV)) dut_hw (.sys_clk(sys_clk),
		.sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata(rd_hw),
		.stop_req(stop_req), .wake_irq(wake_irq), .nmi_pin(nmi_pin),
		.stop_mode(stop_hw), .stop_as_wait(wait_hw),
		.sys_reset_req(rst_hw));

	// clock generator
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// cut a hung run short
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			n_errors++;
			complete_run();
		end
	end

	task automatic complete_run();
		if (n_errors == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : complete_run

	task automatic check(input string what, input logic [7:0] exp, got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// reset held twelve cycles, released at an edge
	task automatic do_reset();
		@(posedge sys_clk) sys_rst <= 1'b1;
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'b0;
	endtask : do_reset

	// write returns at the edge that takes it
	task automatic bus_wr(input logic [7:0] d);
		@(posedge sys_clk) bus_req <= '{WDG_ADDR, 1'b1, 1'b0, d};
		@(posedge sys_clk) bus_req <= '{WDG_ADDR, 1'b0, 1'b0, 8'h00};
	endtask : bus_wr

	task automatic bus_rd(input logic [7:0] a);
		@(posedge sys_clk) bus_req <= '{a, 1'b0, 1'b1, 8'h00};
		@(posedge sys_clk) bus_req <= '{WDG_ADDR, 1'b0, 1'b0, 8'h00};
		@(posedge sys_clk) #1;
		rs = rd_sw;
		rh = rd_hw;
	endtask : bus_rd

	task automatic stop_pulse();
		@(posedge sys_clk) stop_req <= 1'b1;
		@(posedge sys_clk) stop_req <= 1'b0;
		#1;
	endtask : stop_pulse

	// count edges until a reset request of the given build shows
	task automatic wait_rst(input bit hw);
		k = 0;
		while ((hw ? rst_hw : rst_sw) !== 1'b1 && k < 300) begin
			@(posedge sys_clk) #1;
			k++;
		end
	endtask : wait_rst

	task automatic t_reset_values();
		do_reset();
		bus_rd(WDG_ADDR);
		check("reset value", 8'hFE, rs);
		check("hw activation bit", 8'hFF, rh);
		bus_rd(8'hD9);
		check("unmapped read keeps data", 8'hFE, rs);
	endtask : t_reset_values

	task automatic t_reload_read();
		do_reset();
		bus_wr(8'hA2);
		bus_rd(WDG_ADDR);
		check("reversed count readback", 8'hA2, rs);
	endtask : t_reload_read

	task automatic t_sw_reset();
		do_reset();
		bus_wr(8'hFC);
		#1;
		check("sw reset pulse", 8'h01, {7'h00, rst_sw});
		@(posedge sys_clk) #1;
		check("sw reset ends", 8'h00, {7'h00, rst_sw});
	endtask : t_sw_reset

	task automatic t_sticky_timeout();
		do_reset();
		bus_wr(8'h83);
		bus_wr(8'h82);
		bus_rd(WDG_ADDR);
		check("activation sticks", 8'h83, rs);
		bus_wr(8'h82);
		wait_rst(1'b0);
		// count one loaded: two prescale periods to bit 6 falling
		check("timeout cycles", 8'h01,
			{7'h00, k >= 2 * DIV && k <= 2 * DIV + 2});
	endtask : t_sticky_timeout

	task automatic t_timer_mode();
		do_reset();
		bus_wr(8'h02);
		seen = 1'b0;
		repeat (40) begin
			@(posedge sys_clk) #1;
			seen |= rst_sw;
		end
		check("timer gives no reset", 8'h00, {7'h00, seen});
		bus_rd(WDG_ADDR);
		check("timer two steps", 8'h7C, rs);
		// unarmed software build may really stop; hardware build waits
		stop_pulse();
		check("unarmed stop entered", 8'h01, {7'h00, stop_sw});
		check("hw stop as wait, pin low", 8'h01, {7'h00, wait_hw});
		@(posedge sys_clk) wake_irq <= 1'b1;
		@(posedge sys_clk) wake_irq <= 1'b0;
		#1;
		check("wake leaves stop", 8'h00, {7'h00, stop_sw});
	endtask : t_timer_mode

	task automatic t_stop_gating();
		do_reset();
		bus_wr(8'h83);
		stop_pulse();
		check("stop as wait, pin low", 8'h01, {7'h00, wait_hw});
		check("sw armed stop as wait", 8'h01, {7'h00, wait_sw});
		@(posedge sys_clk) nmi_pin <= 1'b1;
		repeat (3) @(posedge sys_clk);
		bus_wr(8'h83);
		stop_pulse();
		check("stop entered", 8'h01, {7'h00, stop_hw});
		check("sw stop ignores pin", 8'h01, {7'h00, wait_sw});
		seen = 1'b0;
		repeat (3 * DIV) begin
			@(posedge sys_clk) #1;
			seen |= rst_hw | ~stop_hw;
		end
		check("frozen in stop", 8'h00, {7'h00, seen});
		@(posedge sys_clk) wake_irq <= 1'b1;
		@(posedge sys_clk) wake_irq <= 1'b0;
		bus_rd(WDG_ADDR);
		check("held count after wake", 8'h83, rh);
		wait_rst(1'b1);
		check("resumes to reset", 8'h01, {7'h00, k <= 2 * DIV + 2});
	endtask : t_stop_gating

	// main sequence
	initial begin
		sys_rst  = 1'b1;
		stop_req = 1'b0;
		wake_irq = 1'b0;
		nmi_pin  = 1'b0;
		bus_req  = '{WDG_ADDR, 1'b0, 1'b0, 8'h00};
		n_errors = 0;
		n_checks = 0;
		cycles   = 0;
		t_reset_values();
		t_reload_read();
		t_sw_reset();
		t_sticky_timeout();
		t_timer_mode();
		t_stop_gating();
		complete_run();
	end
endmodule : watchdog_downcounter_tb
